// file: hdl/twe_pkg.sv
// shared constants and types for the three-wire eeprom command logic
package twe_pkg;
	localparam int          ADDR_W8       = 11;
	localparam int          ADDR_W16      = 10;
	localparam int          MEM_BYTES     = 2048;
	localparam logic [1:0]  OP_EXT        = 2'h0;
	localparam logic [1:0]  OP_WRITE      = 2'h1;
	localparam logic [1:0]  OP_READ       = 2'h2;
	localparam logic [1:0]  OP_ERASE      = 2'h3;
	localparam logic [1:0]  SUB_LOCK      = 2'h0;
	localparam logic [1:0]  SUB_BULK_WR   = 2'h1;
	localparam logic [1:0]  SUB_BULK_ER   = 2'h2;
	localparam logic [1:0]  SUB_UNLOCK    = 2'h3;
	localparam int          CLK_MHZ       = 100;
	localparam int          PROG_TIME_US  = 3000;
	localparam int          PROG_CYC      = PROG_TIME_US * CLK_MHZ;
	localparam int          POR_TIME_US   = 1;
	localparam int          POR_CYC       = POR_TIME_US * CLK_MHZ;
	localparam int          FIFO_DEPTH    = 32;
	localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
	typedef enum logic [2:0] {
		TWE_IDLE, TWE_CMD, TWE_DATA, TWE_READ, TWE_BUSY
	} twe_state_t;
endpackage : twe_pkg

// file: hdl/twe_sync.sv
// two-flop synchroniser with edge detection for the link pins
`timescale 1ns/1ps
module twe_sync (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic din,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} twe_sync_st_t;
	twe_sync_st_t st_q, st_d;
	// first stage feeds only the second
	always_comb begin
		st_d    = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign level = st_q.s2;
	assign rise  = st_q.s2 & ~st_q.s3;
	assign fall  = ~st_q.s2 & st_q.s3;
endmodule // twe_sync

// file: hdl/twe_fifo.sv
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/1ps
module twe_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} twe_fifo_st_t;
	twe_fifo_st_t st_q, st_d;
	logic push;
	logic pop;
	assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_q.cnt != '0);
	assign push      = in_valid & in_ready & ~flush;
	assign pop       = out_valid & out_ready & ~flush;
	assign out_data  = mem[st_q.rp];
	// pointer and count update; flush empties at once
	always_comb begin
		st_d = st_q;
		if (flush) begin
			st_d = '0;
		end else begin
			if (push) begin
				st_d.wp = st_q.wp + 1'b1;
			end
			if (pop) begin
				st_d.rp = st_q.rp + 1'b1;
			end
			st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	// storage holds no reset, it is only read behind valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem[st_q.wp] <= in_data;
		end
	end
endmodule // twe_fifo

// file: hdl/twe_core.sv
// command decoder, read streamer and array access of the three-wire eeprom
// Behaviour
// - commands ignored while internal power-on reset holds; standby after release.
// - instruction starts on select rise; start bit, 2-bit opcode, address, msb first.
// - opcode 10 reads; 11-bit address in byte mode, 10-bit in word mode.
// - opcode 00 with address 11xx sets program unlock.
// - opcode 11 with address erases that word.
// - opcode 01 with address and data programs that word.
// - opcode 00 with address 10xx erases the whole array.
// - opcode 00 with address 01xx plus data writes every location.
// - opcode 00 with address 00xx clears program unlock.
// - read data goes out, changing only on rising serial clock edges.
// - while selected after a word, pointer increments and next word follows directly.
// - one zero dummy bit precedes the first read word.
// - program unlock is clear after power up.
// - programming commands act only while unlocked, else array untouched.
// - unlock persists across instructions until lock or power loss.
// - reads work whether locked or unlocked.
// - single erase starts once opcode and address decoded, sets word to ones.
// - after programming, select low then high while the cycle runs shows ready/busy on output.
// - status reads one when the self-timed cycle is done.
// - status reads zero while the self-timed cycle runs.
`timescale 1ns/1ps
module twe_core
	import twe_pkg::*;
#(
	parameter int PROG_CYCLES = twe_pkg::PROG_CYC,
	parameter int POR_CYCLES  = twe_pkg::POR_CYC
) (
	input  wire logic CORE_CLK,
	input  wire logic NRST,
	input  wire logic CHIP_SELECT,
	input  wire logic SERIAL_CLOCK,
	input  wire logic SERIAL_IN,
	input  wire logic WIDTH_SELECT_PIN,
	output logic      SERIAL_OUT,
	output logic      SERIAL_OUT_OE,
	output logic      BUSY
);
	import twe_pkg::*;

	localparam int CW = $clog2(PROG_CYCLES + 1);
	localparam int PW = $clog2(POR_CYCLES + 1);

	logic [7:0] mem [MEM_BYTES];

	typedef struct packed {
		twe_state_t  state;
		logic [PW-1:0] por_cnt;
		logic        por_done;
		logic        wide;
		logic        unlocked;
		logic [4:0]  bits;
		logic [1:0]  op;
		logic [10:0] addr;
		logic [15:0] wdata;
		logic [15:0] shreg;
		logic [4:0]  rbits;
		logic        dout;
		logic        oe;
		logic        show_status;
		logic [CW-1:0] prog_cnt;
		logic        prog_kind_bulk;
		logic        prog_erase;
		logic        prog_pending;
		logic [10:0] prog_addr;
		logic [15:0] prog_data;
		logic        prog_go;
	} twe_core_st_t;
	twe_core_st_t st_q, st_d;

	logic cs_lvl, cs_rise, cs_fall;
	logic sk_rise;
	logic ws_lvl;
	logic di_lvl;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [15:0] fifo_out_data;
	logic fifo_push;
	logic [15:0] fifo_in_data;
	logic flush;

	// address length of the current width mode
	function automatic logic [4:0] addr_len(input logic wide);
		return wide ? 5'(ADDR_W16) : 5'(ADDR_W8);
	endfunction
	// byte index of a word address in the current mode
	function automatic logic [10:0] byte_of(input logic wide, input logic [10:0] a);
		return wide ? {a[9:0], 1'b0} : a;
	endfunction

	twe_sync u_cs (.clk(CORE_CLK), .nrst(NRST), .din(CHIP_SELECT),
		.level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
	twe_sync u_sk (.clk(CORE_CLK), .nrst(NRST), .din(SERIAL_CLOCK),
		.level(), .rise(sk_rise), .fall());
	twe_sync u_di (.clk(CORE_CLK), .nrst(NRST), .din(SERIAL_IN),
		.level(di_lvl), .rise(), .fall());
	// width pin is quasi-static but still crosses into this clock
	twe_sync u_ws (.clk(CORE_CLK), .nrst(NRST), .din(WIDTH_SELECT_PIN),
		.level(ws_lvl), .rise(), .fall());

	// read words queue between array fetch and the shifter; fetch stalls when full
	twe_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CORE_CLK), .nrst(NRST), .flush(flush),
		.in_data(fifo_in_data), .in_valid(fifo_push), .in_ready(fifo_in_ready),
		.out_data(fifo_out_data), .out_valid(fifo_out_valid), .out_ready(fifo_out_ready));

	logic [10:0] fetch_addr;
	logic [10:0] fbyte;
	assign fbyte        = byte_of(st_q.wide, fetch_addr);
	assign fifo_in_data = st_q.wide ? {mem[fbyte], mem[fbyte + 11'h001]} : {8'h00, mem[fbyte]};
	assign flush        = (st_q.state != TWE_READ);

	// fetch pointer runs ahead of the shifter through the fifo
	logic [10:0] fetch_q;
	assign fetch_addr = fetch_q;
	assign fifo_push  = (st_q.state == TWE_READ);
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			fetch_q <= '0;
		end else if (st_q.state != TWE_READ) begin
			fetch_q <= st_d.addr; // next value, so the last address bit is already in
		end else if (fifo_in_ready) begin
			fetch_q <= st_q.wide ? {1'b0, fetch_q[9:0] + 10'h001} : fetch_q + 11'h001;
		end
	end
	assign fifo_out_ready = (st_q.state == TWE_READ) && sk_rise && (st_q.rbits == 5'h00);

	assign SERIAL_OUT    = st_q.dout;
	assign SERIAL_OUT_OE = st_q.oe;
	assign BUSY          = st_q.prog_pending;

	// word to store and its first byte; erase stores all ones
	logic [15:0] pword;
	logic [10:0] pbyte;
	assign pword = st_q.prog_erase ? {ERASED_BYTE, ERASED_BYTE} : st_q.prog_data;
	assign pbyte = byte_of(st_q.wide, st_q.prog_addr);

	// state register, synchronous active-low reset clears the unlock flag
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// array is updated once when a job is accepted; the busy counter only
	// models the self-timed length, so a read after ready sees new data
	always_ff @(posedge CORE_CLK) begin
		if (st_q.prog_go) begin
			if (st_q.prog_kind_bulk) begin
				for (int i = 0; i < MEM_BYTES; i++) begin
					mem[i] <= (st_q.wide && !i[0]) ? pword[15:8] : pword[7:0];
				end
			end else if (st_q.wide) begin
				mem[pbyte]          <= pword[15:8];
				mem[pbyte + 11'h001] <= pword[7:0];
			end else begin
				mem[pbyte] <= pword[7:0];
			end
		end
	end

	always_comb begin
		st_d = st_q;
		st_d.prog_go = 1'b0;
		// power-on lockout counter
		if (!st_q.por_done) begin
			st_d.por_cnt = st_q.por_cnt + 1'b1;
			if (st_q.por_cnt == PW'(POR_CYCLES)) begin
				st_d.por_done = 1'b1;
			end
		end
		// self-timed programming, same length for bulk jobs, whose locations are all written in one cycle
		if (st_q.prog_pending) begin
			st_d.prog_cnt = st_q.prog_cnt - 1'b1;
			if (st_q.prog_cnt == '0) begin
				st_d.prog_pending = 1'b0;
			end
		end
		// select drop abandons the instruction; a running program cycle continues
		if (cs_fall) begin
			st_d.state       = TWE_IDLE;
			st_d.oe          = 1'b0;
			st_d.show_status = 1'b0;
		end else if (cs_rise && st_q.por_done) begin
			st_d.wide  = ws_lvl;
			st_d.bits  = '0;
			st_d.dout  = 1'b0;
			if (st_q.prog_pending || st_q.show_status) begin
				st_d.show_status = st_q.prog_pending;
				st_d.oe          = st_q.prog_pending;
				st_d.state       = st_q.prog_pending ? TWE_BUSY : TWE_CMD;
			end else begin
				st_d.state = TWE_CMD;
			end
		end else begin
			unique case (st_q.state)
				TWE_IDLE: begin
				end
				TWE_BUSY: begin
					st_d.dout = ~st_q.prog_pending;
					if (!st_q.prog_pending) begin
						st_d.state = TWE_IDLE;
					end
				end
				TWE_CMD: begin
					if (sk_rise && cs_lvl) begin
						if (st_q.bits == '0) begin
							if (di_lvl) begin
								st_d.bits = 5'h01;
							end
						end else if (st_q.bits < 5'h03) begin
							st_d.op   = {st_q.op[0], di_lvl};
							st_d.bits = st_q.bits + 5'h01;
						end else begin
							st_d.addr = {st_q.addr[9:0], di_lvl};
							st_d.bits = st_q.bits + 5'h01;
							if (st_q.bits == addr_len(st_q.wide) + 5'h02) begin
								st_d.bits = '0;
								st_d.addr = st_q.wide ? {1'b0, st_q.addr[8:0], di_lvl} : {st_q.addr[9:0], di_lvl};
								unique case (st_q.op)
									OP_READ: begin
										st_d.state = TWE_READ;
										st_d.rbits = 5'h00;
										st_d.dout  = 1'b0;
										st_d.oe    = 1'b1;
									end
									OP_ERASE: begin
										st_d.state = TWE_IDLE;
										st_d.prog_pending   = st_q.unlocked;
										st_d.prog_go        = st_q.unlocked;
										st_d.prog_addr      = st_q.wide ? {1'b0, st_q.addr[8:0], di_lvl}
											: {st_q.addr[9:0], di_lvl};
										st_d.prog_erase     = 1'b1;
										st_d.prog_kind_bulk = 1'b0;
										st_d.prog_cnt       = CW'(PROG_CYCLES);
										st_d.show_status    = st_q.unlocked;
									end
									OP_WRITE: begin
										st_d.state      = TWE_DATA;
										st_d.prog_erase = 1'b0;
										st_d.prog_kind_bulk = 1'b0;
									end
									default: begin
										st_d.state = TWE_IDLE;
										unique case (st_q.wide ? st_q.addr[8:7] : st_q.addr[9:8])
											SUB_UNLOCK: st_d.unlocked = 1'b1;
											SUB_LOCK: st_d.unlocked = 1'b0;
											SUB_BULK_ER: begin
												st_d.prog_pending   = st_q.unlocked;
												st_d.prog_go        = st_q.unlocked;
												st_d.prog_erase     = 1'b1;
												st_d.prog_kind_bulk = 1'b1;
												st_d.prog_cnt       = CW'(PROG_CYCLES);
												st_d.show_status    = st_q.unlocked;
											end
											SUB_BULK_WR: begin
												st_d.state          = TWE_DATA;
												st_d.prog_erase     = 1'b0;
												st_d.prog_kind_bulk = 1'b1;
											end
										endcase
									end
								endcase
							end
						end
					end
				end
				TWE_DATA: begin
					if (sk_rise && cs_lvl) begin
						st_d.wdata = {st_q.wdata[14:0], di_lvl};
						st_d.bits  = st_q.bits + 5'h01;
						if (st_q.bits == (st_q.wide ? 5'h0F : 5'h07)) begin
							st_d.state        = TWE_IDLE;
							st_d.prog_pending = st_q.unlocked;
							st_d.prog_go      = st_q.unlocked;
							st_d.prog_data    = {st_q.wdata[14:0], di_lvl};
							st_d.prog_addr    = st_q.addr;
							st_d.prog_cnt     = CW'(PROG_CYCLES);
							st_d.show_status  = st_q.unlocked;
						end
					end
				end
				TWE_READ: begin
					if (sk_rise) begin
						if (st_q.rbits == 5'h00) begin
							// next word follows with no lead bit between words
							if (fifo_out_valid) begin
								st_d.dout  = st_q.wide ? fifo_out_data[15] : fifo_out_data[7];
								st_d.shreg = st_q.wide ? {fifo_out_data[14:0], 1'b0}
									: {fifo_out_data[6:0], 9'h000};
								st_d.rbits = st_q.wide ? 5'h0F : 5'h07;
							end
						end else begin
							st_d.dout  = st_q.shreg[15];
							st_d.shreg = {st_q.shreg[14:0], 1'b0};
							st_d.rbits = st_q.rbits - 5'h01;
						end
					end
				end
				default: st_d.state = TWE_IDLE;
			endcase
		end
	end
endmodule // twe_core

// file: dv/twe_host.sv
// host-side model driving the three-wire link
`timescale 1ns/1ps
module twe_host (
	input  wire logic clk,
	input  wire logic dout,
	output logic      cs,
	output logic      sk,
	output logic      di
);
	initial begin
		cs = 1'b0;
		sk = 1'b0;
		di = 1'b0;
	end
	// one 160 ns link period; output sampled just before the rise
	task automatic xbit(input logic b, output logic r);
		di <= b;
		repeat (8) @(posedge clk);
		r = dout;
		sk <= 1'b1;
		repeat (8) @(posedge clk);
		sk <= 1'b0;
	endtask
	// select, then every bit msb first, don't-care ones included
	task automatic send(input logic [31:0] v, input int n);
		logic r;
		cs <= 1'b1;
		for (int i = n - 1; i >= 0; i--) xbit(v[i], r);
	endtask
	// input toggles while reading so no stale level is left
	task automatic rd(input int n, output logic [63:0] w);
		logic r;
		w = '0;
		for (int i = n - 1; i >= 0; i--) begin
			xbit(~di, r);
			w[i] = r;
		end
	endtask
	// deselect and keep the line low past the minimum low time
	task automatic stop();
		di <= ~di;
		cs <= 1'b0;
		repeat (30) @(posedge clk);
	endtask
	task automatic power_wait(input int n);
		repeat (n + 50) @(posedge clk);
	endtask
	// reselect and watch ready/busy, bounded by lim cycles
	task automatic status(input int lim, output logic first, output logic last);
		cs <= 1'b1;
		repeat (30) @(posedge clk);
		first = dout;
		for (int i = 0; i < lim && dout !== 1'b1; i++) @(posedge clk);
		repeat (12) @(posedge clk);
		last = dout;
		stop();
	endtask
endmodule // twe_host

// file: dv/twe_core_chk.sv
// port checker for the three-wire eeprom command logic
`timescale 1ns/1ps
module twe_core_chk #(
	parameter int PROG_CYCLES = twe_pkg::PROG_CYC,
	parameter int POR_CYCLES  = twe_pkg::POR_CYC
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic CHIP_SELECT,
	input wire logic SERIAL_CLOCK,
	input wire logic SERIAL_IN,
	input wire logic WIDTH_SELECT_PIN,
	input wire logic SERIAL_OUT,
	input wire logic SERIAL_OUT_OE,
	input wire logic BUSY
);
	logic        sk_q, stat_q;
	logic [15:0] since_q, cshi_q, cslo_q, idle_q, por_q;
	logic [31:0] blen_q;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	function automatic logic [15:0] inc(logic [15:0] v);
		return (v == 16'hFFFF) ? v : v + 16'h1;
	endfunction
	// saturating 16-bit cycle counters, blen_q wraps; stat_q marks a select made while busy
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			sk_q <= 1'b0;
			stat_q <= 1'b0;
			since_q <= 16'hFFFF;
			{cshi_q, cslo_q, idle_q, por_q} <= '0;
			blen_q <= 32'h0;
		end else begin
			sk_q <= SERIAL_CLOCK;
			since_q <= (SERIAL_CLOCK && !sk_q) ? 16'h0 : inc(since_q);
			cshi_q <= CHIP_SELECT ? inc(cshi_q) : 16'h0;
			cslo_q <= CHIP_SELECT ? 16'h0 : inc(cslo_q);
			idle_q <= BUSY ? 16'h0 : inc(idle_q);
			por_q <= inc(por_q);
			blen_q <= BUSY ? blen_q + 32'h1 : 32'h0;
			stat_q <= CHIP_SELECT && (stat_q || (cshi_q == 16'h0 && BUSY));
		end
	end
	chk_out_on_rise: assert property (CHIP_SELECT && cshi_q > 16'd8 && idle_q > 16'd8 && SERIAL_OUT_OE
		&& $past(SERIAL_OUT_OE) && $changed(SERIAL_OUT) |-> since_q <= 16'd8) else $error("output moved off clock");
	chk_oe_release: assert property (SERIAL_OUT_OE |-> cslo_q <= 16'd15) else $error("output kept after deselect");
	chk_por_quiet: assert property (por_q < POR_CYCLES |-> !BUSY && !SERIAL_OUT_OE) else $error("active in reset");
	chk_busy_time: assert property ($fell(BUSY) |-> blen_q >= PROG_CYCLES - 2 && blen_q <= PROG_CYCLES + 2)
		else $error("busy length wrong");
	chk_busy_hold: assert property ($rose(BUSY) |=> BUSY [*8]) else $error("busy too short");
	chk_busy_start: assert property ($rose(BUSY) |-> CHIP_SELECT || cslo_q < 16'd8) else $error("busy unprompted");
	chk_status_busy: assert property (stat_q && BUSY && cshi_q > 16'd25 |-> SERIAL_OUT_OE && !SERIAL_OUT)
		else $error("status not busy");
	chk_status_ready: assert property (stat_q && idle_q > 16'd8 && cshi_q > 16'd25 |-> SERIAL_OUT_OE && SERIAL_OUT)
		else $error("status not ready");
endmodule // twe_core_chk
bind twe_core twe_core_chk #(.PROG_CYCLES(PROG_CYCLES), .POR_CYCLES(POR_CYCLES)) u_chk (
	.CORE_CLK(CORE_CLK), .NRST(NRST), .CHIP_SELECT(CHIP_SELECT), .SERIAL_CLOCK(SERIAL_CLOCK),
	.SERIAL_IN(SERIAL_IN), .WIDTH_SELECT_PIN(WIDTH_SELECT_PIN), .SERIAL_OUT(SERIAL_OUT),
	.SERIAL_OUT_OE(SERIAL_OUT_OE), .BUSY(BUSY)
);

// file: dv/twe_core_test.sv
// self-checking bench for the three-wire eeprom command logic
`timescale 1ns/1ps
module twe_core_test;
	import twe_pkg::*;
	localparam int PROG  = 2000;
	localparam int POR   = 20;
	localparam int LIMIT = 90000;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        wsel = 1'b1;
	logic        last_q = 1'b0;
	logic        so, oe, busy, cs, sk, di, line_v, b0, b1;
	logic [63:0] w;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cycles = 0;
	twe_core #(.PROG_CYCLES(PROG), .POR_CYCLES(POR)) u_dut (
		.CORE_CLK(clk), .NRST(nrst), .CHIP_SELECT(cs), .SERIAL_CLOCK(sk), .SERIAL_IN(di),
		.WIDTH_SELECT_PIN(wsel), .SERIAL_OUT(so), .SERIAL_OUT_OE(oe), .BUSY(busy)
	);
	twe_host u_host (.clk(clk), .dout(line_v), .cs(cs), .sk(sk), .di(di));
	always #5 clk = ~clk;
	// a released output line shows the inverse of its last level
	always @(posedge clk) if (oe) last_q <= so;
	assign line_v = oe ? so : ~last_q;
	// hang guard sized well past the expected run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: bit %b wanted %b", $time, got, exp);
		end
	endtask
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: word %h wanted %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] ins, input int n);
		u_host.send(ins, n);
		u_host.stop();
	endtask
	// two words after the zero lead bit, no lead bit between them
	task automatic rd_chk(input logic [31:0] ins, input int n, input int wb, input logic [15:0] e0, e1);
		logic [15:0] m;
		m = (wb == 16) ? 16'hFFFF : 16'h00FF;
		u_host.send(ins, n);
		u_host.rd(1 + 2 * wb, w);
		u_host.stop();
		cmp_bit(w[2 * wb], 1'b0);
		cmp_word(16'(w >> wb) & m, e0);
		cmp_word(16'(w) & m, e1);
	endtask
	task automatic prog_wait();
		u_host.status(PROG + 100, b0, b1);
		cmp_bit(b0, 1'b0);
		cmp_bit(b1, 1'b1);
	endtask
	task automatic t_erase_all();
		wr({1'b1, OP_EXT, SUB_UNLOCK, 8'h5A}, 13);
		wr({1'b1, OP_EXT, SUB_BULK_ER, 8'hA5}, 13);
		prog_wait();
		rd_chk({1'b1, OP_READ, 10'h000}, 13, 16, 16'hFFFF, 16'hFFFF);
	endtask
	task automatic t_write_erase();
		wr({1'b1, OP_WRITE, 10'h003, 16'hA5C3}, 29);
		prog_wait();
		wr({1'b1, OP_WRITE, 10'h004, 16'h0F0F}, 29);
		prog_wait();
		rd_chk({1'b1, OP_READ, 10'h003}, 13, 16, 16'hA5C3, 16'h0F0F);
		wr({1'b1, OP_ERASE, 10'h003}, 13);
		prog_wait();
		rd_chk({1'b1, OP_READ, 10'h003}, 13, 16, 16'hFFFF, 16'h0F0F);
	endtask
	// locked: programming ignored, reads still served
	task automatic t_locked();
		wr({1'b1, OP_EXT, SUB_LOCK, 8'hA5}, 13);
		wr({1'b1, OP_WRITE, 10'h004, 16'h0000}, 29);
		wr({1'b1, OP_EXT, SUB_BULK_ER, 8'h00}, 13);
		cmp_bit(busy, 1'b0);
		rd_chk({1'b1, OP_READ, 10'h003}, 13, 16, 16'hFFFF, 16'h0F0F);
	endtask
	// aborted frame, then a write refused while the array is busy
	task automatic t_abort_busy();
		wr({1'b1, OP_EXT, SUB_UNLOCK, 8'hC3}, 13);
		wr({1'b1, OP_WRITE, 10'h004}, 13);
		wr({1'b1, OP_EXT, SUB_BULK_WR, 8'h00, 16'h5A5A}, 29);
		wr({1'b1, OP_WRITE, 10'h005, 16'h0000}, 29);
		prog_wait();
		rd_chk({1'b1, OP_READ, 10'h004}, 13, 16, 16'h5A5A, 16'h5A5A);
	endtask
	task automatic t_bytes();
		wsel <= 1'b0;
		@(posedge clk);
		wr({1'b1, OP_WRITE, 11'h7FF, 8'hC3}, 22);
		prog_wait();
		rd_chk({3'b000, 1'b1, OP_READ, 11'h7FE}, 17, 8, 16'h005A, 16'h00C3);
		wr({1'b1, OP_EXT, SUB_LOCK, 9'h000}, 14);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		u_host.power_wait(POR);
		t_erase_all();
		t_write_erase();
		t_locked();
		t_abort_busy();
		t_bytes();
		give_verdict();
	end
endmodule // twe_core_test
